/* File: psrb_bank.sv */
// Purpose: software-held reset lines for peripheral units
// Assumes: single bus clock, synchronous active-high reset
// Notes: outputs come straight from register flip-flops
`timescale 1ns/100ps
`default_nettype none

module psrb_bank
  import psrb_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // high-speed group resets
  output logic o_altfunc_io_reset_bit,
  output logic [4:0] o_io_port_reset_bit,
  output logic o_converter_a_reset_bit,
  output logic o_converter_b_reset_bit,
  output logic o_adv_timer_reset_bit,
  output logic o_spi_unit0_reset_bit,
  output logic o_serial_port0_reset_bit,
  // low-speed group resets
  output logic o_spi_unit1_reset_bit,
  output logic o_spi_unit2_reset_bit,
  output logic [3:0] o_serial_port_reset_bit,
  output logic o_two_wire_a_reset_bit,
  output logic o_two_wire_b_reset_bit,
  output logic o_can_ctrl_a_reset_bit,
  output logic o_can_ctrl_b_reset_bit,
  output logic o_backup_if_reset_bit,
  output logic o_power_ctrl_reset_bit,
  output logic o_analog_out_reset_bit
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [31:0] hs;
    logic [31:0] ls;
    logic [31:0] rdata;
  } psrb_state_type;

  psrb_state_type st_q;
  psrb_state_type st_d;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.rdata = 32'h0000_0000;
    if (i_wr && i_addr == PSRB_HS_OFFSET) begin
      st_d.hs = i_wdata & PSRB_HS_MASK;
    end
    if (i_wr && i_addr == PSRB_LS_OFFSET) begin
      st_d.ls = i_wdata & PSRB_LS_MASK;
    end
    if (i_rd) begin
      unique case (i_addr)
        PSRB_HS_OFFSET: st_d.rdata = st_q.hs;
        PSRB_LS_OFFSET: st_d.rdata = st_q.ls;
        default: st_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      st_q.hs <= PSRB_HS_RESET;
      st_q.ls <= PSRB_LS_RESET;
      st_q.rdata <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign o_rdata = st_q.rdata;
  assign o_altfunc_io_reset_bit = st_q.hs[PSRB_HS_ALTFUNC_IO];
  assign o_io_port_reset_bit = st_q.hs[PSRB_HS_IO_PORT_E:PSRB_HS_IO_PORT_A];
  assign o_converter_a_reset_bit = st_q.hs[PSRB_HS_CONV_A];
  assign o_converter_b_reset_bit = st_q.hs[PSRB_HS_CONV_B];
  assign o_adv_timer_reset_bit = st_q.hs[PSRB_HS_ADV_TIMER];
  assign o_spi_unit0_reset_bit = st_q.hs[PSRB_HS_SPI0];
  assign o_serial_port0_reset_bit = st_q.hs[PSRB_HS_SERIAL0];
  assign o_spi_unit1_reset_bit = st_q.ls[PSRB_LS_SPI1];
  assign o_spi_unit2_reset_bit = st_q.ls[PSRB_LS_SPI2];
  assign o_serial_port_reset_bit = st_q.ls[PSRB_LS_SERIAL4:PSRB_LS_SERIAL1];
  assign o_two_wire_a_reset_bit = st_q.ls[PSRB_LS_TWO_WIRE_A];
  assign o_two_wire_b_reset_bit = st_q.ls[PSRB_LS_TWO_WIRE_B];
  assign o_can_ctrl_a_reset_bit = st_q.ls[PSRB_LS_CAN_A];
  assign o_can_ctrl_b_reset_bit = st_q.ls[PSRB_LS_CAN_B];
  assign o_backup_if_reset_bit = st_q.ls[PSRB_LS_BACKUP_IF];
  assign o_power_ctrl_reset_bit = st_q.ls[PSRB_LS_POWER_CTRL];
  assign o_analog_out_reset_bit = st_q.ls[PSRB_LS_ANALOG_OUT];

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_hold_value;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      !(i_wr && (i_addr == PSRB_LS_OFFSET)) |=> ($stable(st_q.ls) || $past(i_sys_rst));
  endproperty
  a_hold_value: assert property (p_hold_value) else $error("ls reg changed without write");

  property p_io_ports;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_wr && i_addr == PSRB_HS_OFFSET) |=> (o_io_port_reset_bit == $past(i_wdata[6:2]));
  endproperty
  a_io_ports: assert property (p_io_ports) else $error("io port resets wrong");

  property p_altfunc;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_wr && i_addr == PSRB_HS_OFFSET) |=> (o_altfunc_io_reset_bit == $past(i_wdata[0]));
  endproperty
  a_altfunc: assert property (p_altfunc) else $error("altfunc reset wrong");

  property p_power;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_wr && i_addr == PSRB_LS_OFFSET) |=> (o_power_ctrl_reset_bit == $past(i_wdata[28]));
  endproperty
  a_power: assert property (p_power) else $error("power ctrl reset wrong");

  property p_backup;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_wr && i_addr == PSRB_LS_OFFSET) |=> (o_backup_if_reset_bit == $past(i_wdata[27]));
  endproperty
  a_backup: assert property (p_backup) else $error("backup if reset wrong");

  property p_can;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_wr && i_addr == PSRB_LS_OFFSET)
        |=> ({o_can_ctrl_b_reset_bit, o_can_ctrl_a_reset_bit} == $past(i_wdata[26:25]));
  endproperty
  a_can: assert property (p_can) else $error("can resets wrong");

  property p_reserved;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      i_rd ##1 1'b1 |-> ((o_rdata & ~PSRB_HS_MASK & ~PSRB_LS_MASK) == 32'h0000_0000);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero");

  property p_reset_clear;
    @(posedge i_ref_clk) i_sys_rst |=> (o_power_ctrl_reset_bit == 1'b0 && o_rdata == 32'h0);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("not clear after reset");

  property p_readback;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_rd && i_addr == PSRB_LS_OFFSET) |=> (o_rdata == {2'b00, o_analog_out_reset_bit,
        o_power_ctrl_reset_bit, o_backup_if_reset_bit, o_can_ctrl_b_reset_bit,
        o_can_ctrl_a_reset_bit, 2'b00, o_two_wire_b_reset_bit, o_two_wire_a_reset_bit,
        o_serial_port_reset_bit, 1'b0, o_spi_unit2_reset_bit, o_spi_unit1_reset_bit, 14'h0000});
  endproperty
  a_readback: assert property (p_readback) else $error("ls readback mismatch");

  property p_release;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_wr && i_addr == PSRB_HS_OFFSET && !i_wdata[14]) |=> !o_serial_port0_reset_bit;
  endproperty
  a_release: assert property (p_release) else $error("serial0 not released");

  property p_hold_hs;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      !(i_wr && (i_addr == PSRB_HS_OFFSET)) |=> ($stable(st_q.hs) || $past(i_sys_rst));
  endproperty
  a_hold_hs: assert property (p_hold_hs) else $error("hs reg changed");

  property p_hs_keep_mask;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (st_q.hs & ~PSRB_HS_MASK) == 32'h0000_0000;
  endproperty
  a_hs_keep_mask: assert property (p_hs_keep_mask) else $error("hs reserved set");

  property p_ls_keep_mask;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (st_q.ls & ~PSRB_LS_MASK) == 32'h0000_0000;
  endproperty
  a_ls_keep_mask: assert property (p_ls_keep_mask) else $error("ls reserved set");

  property p_hs_read;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_rd && i_addr == PSRB_HS_OFFSET) |=> (o_rdata == $past(st_q.hs));
  endproperty
  a_hs_read: assert property (p_hs_read) else $error("hs read wrong");

  property p_ls_read;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_rd && i_addr == PSRB_LS_OFFSET) |=> (o_rdata == $past(st_q.ls));
  endproperty
  a_ls_read: assert property (p_ls_read) else $error("ls read wrong");

  property p_hs_read_rsvd;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_rd && i_addr == PSRB_HS_OFFSET) |=> ((o_rdata & ~PSRB_HS_MASK) == 32'h0000_0000);
  endproperty
  a_hs_read_rsvd: assert property (p_hs_read_rsvd) else $error("hs rsvd read");

  property p_ls_read_rsvd;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_rd && i_addr == PSRB_LS_OFFSET) |=> ((o_rdata & ~PSRB_LS_MASK) == 32'h0000_0000);
  endproperty
  a_ls_read_rsvd: assert property (p_ls_read_rsvd) else $error("ls rsvd read");

  property p_unmapped_read;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_rd && i_addr != PSRB_HS_OFFSET && i_addr != PSRB_LS_OFFSET)
        |=> (o_rdata == 32'h0000_0000);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read");

  property p_unmapped_write;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_wr && i_addr != PSRB_HS_OFFSET && i_addr != PSRB_LS_OFFSET)
        |=> ($stable(st_q.hs) && $stable(st_q.ls));
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped wr");

  property p_rdata_idle;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      !i_rd |=> (o_rdata == 32'h0000_0000);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not idle");

  property p_conv;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_wr && i_addr == PSRB_HS_OFFSET)
        |=> ({o_converter_b_reset_bit, o_converter_a_reset_bit} == $past(i_wdata[10:9]));
  endproperty
  a_conv: assert property (p_conv) else $error("converter resets wrong");

  property p_timer;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_wr && i_addr == PSRB_HS_OFFSET) |=> (o_adv_timer_reset_bit == $past(i_wdata[11]));
  endproperty
  a_timer: assert property (p_timer) else $error("timer reset wrong");

  property p_spi0;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_wr && i_addr == PSRB_HS_OFFSET) |=> (o_spi_unit0_reset_bit == $past(i_wdata[12]));
  endproperty
  a_spi0: assert property (p_spi0) else $error("spi0 reset wrong");

  property p_serial0;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_wr && i_addr == PSRB_HS_OFFSET) |=> (o_serial_port0_reset_bit == $past(i_wdata[14]));
  endproperty
  a_serial0: assert property (p_serial0) else $error("serial0 reset wrong");

  property p_spi_ls;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_wr && i_addr == PSRB_LS_OFFSET)
        |=> ({o_spi_unit2_reset_bit, o_spi_unit1_reset_bit} == $past(i_wdata[15:14]));
  endproperty
  a_spi_ls: assert property (p_spi_ls) else $error("spi1/2 resets wrong");

  property p_serial_ls;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_wr && i_addr == PSRB_LS_OFFSET) |=> (o_serial_port_reset_bit == $past(i_wdata[20:17]));
  endproperty
  a_serial_ls: assert property (p_serial_ls) else $error("serial resets wrong");

  property p_two_wire;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_wr && i_addr == PSRB_LS_OFFSET)
        |=> ({o_two_wire_b_reset_bit, o_two_wire_a_reset_bit} == $past(i_wdata[22:21]));
  endproperty
  a_two_wire: assert property (p_two_wire) else $error("two-wire resets wrong");

  property p_analog;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_wr && i_addr == PSRB_LS_OFFSET) |=> (o_analog_out_reset_bit == $past(i_wdata[29]));
  endproperty
  a_analog: assert property (p_analog) else $error("analog out reset wrong");

  property p_power_release;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_wr && i_addr == PSRB_LS_OFFSET && !i_wdata[28]) |=> !o_power_ctrl_reset_bit;
  endproperty
  a_power_release: assert property (p_power_release) else $error("power not freed");

  property p_ports_release;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_wr && i_addr == PSRB_HS_OFFSET && i_wdata[6:2] == 5'h00)
        |=> (o_io_port_reset_bit == 5'h00);
  endproperty
  a_ports_release: assert property (p_ports_release) else $error("ports not freed");

  property p_reset_regs;
    @(posedge i_ref_clk)
      i_sys_rst |=> (st_q.hs == PSRB_HS_RESET && st_q.ls == PSRB_LS_RESET);
  endproperty
  a_reset_regs: assert property (p_reset_regs) else $error("regs not cleared");

endmodule : psrb_bank

`default_nettype wire

/* File: psrb_bank_tb_top.sv */
// Purpose: self-checking bench for the reset bank
// Assumes: register port, one clock
// Notes: expected bits built from bit positions
`timescale 1ns/100ps
`default_nettype none
module psrb_bank_tb_top
  import psrb_pkg::*;
;
  // ----
  // signals
  // ----
  localparam logic [31:0] HS_DEF = 32'h0000_5e7d;
  localparam logic [31:0] LS_DEF = 32'h3e7e_c000;
  logic i_ref_clk = 1'h0;
  logic i_sys_rst = 1'h1;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'h0;
  logic i_rd = 1'h0;
  logic [31:0] o_rdata, hs_vec, ls_vec;
  logic af, ca, cb, tm, s0, p0, p1, p2, wa, wb, na, nb, bk, pw, an;
  logic [4:0] io;
  logic [3:0] sr;
  logic [63:0] alive;
  int n_mismatch = 0;
  int cmp_count = 0;
  assign hs_vec = {17'h0, s0, 1'h0, p0, tm, cb, ca, 2'h0, io, 1'h0, af};
  assign ls_vec = {2'h0, an, pw, bk, nb, na, 2'h0, wb, wa, sr, 1'h0, p2, p1, 14'h0};
  psrb_bank uut (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_altfunc_io_reset_bit(af), .o_io_port_reset_bit(io), .o_converter_a_reset_bit(ca),
    .o_converter_b_reset_bit(cb), .o_adv_timer_reset_bit(tm), .o_spi_unit0_reset_bit(p0),
    .o_serial_port0_reset_bit(s0), .o_spi_unit1_reset_bit(p1), .o_spi_unit2_reset_bit(p2),
    .o_serial_port_reset_bit(sr), .o_two_wire_a_reset_bit(wa), .o_two_wire_b_reset_bit(wb),
    .o_can_ctrl_a_reset_bit(na), .o_can_ctrl_b_reset_bit(nb), .o_backup_if_reset_bit(bk),
    .o_power_ctrl_reset_bit(pw), .o_analog_out_reset_bit(an));
  psrb_periph_model far (.i_ref_clk(i_ref_clk), .i_unit_rst({ls_vec, hs_vec}),
    .o_unit_alive(alive));
  // ----
  // tasks
  // ----
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'h1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'h0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_ref_clk);
    i_rd <= 1'h1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'h0;
    #1;
    d = o_rdata;
  endtask : rd
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_sim;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  // ----
  // clock, watchdog, tests
  // ----
  initial begin
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    #50000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    logic [31:0] d;
    repeat (8) @(posedge i_ref_clk);
    i_sys_rst <= 1'h0;
    rd(PSRB_LS_OFFSET, d);
    chk("ls reset", d, 32'h0);
    for (int i = 0; i < 32; i++) begin
      wr(PSRB_HS_OFFSET, (32'h1 << i) & HS_DEF);
      chk("hs out", hs_vec, (32'h1 << i) & HS_DEF);
      wr(PSRB_LS_OFFSET, (32'h1 << i) & LS_DEF);
      chk("ls out", ls_vec, (32'h1 << i) & LS_DEF);
    end
    wr(PSRB_HS_OFFSET, HS_DEF);
    wr(PSRB_LS_OFFSET, LS_DEF);
    wr(8'h14, 32'h0);
    repeat (20) @(posedge i_ref_clk);
    rd(PSRB_HS_OFFSET, d);
    chk("hs hold", d, HS_DEF);
    rd(PSRB_LS_OFFSET, d);
    chk("ls hold", d, LS_DEF);
    rd(8'h14, d);
    chk("unmapped", d, 32'h0);
    chk("far hs", alive[31:0], ~HS_DEF);
    wr(PSRB_LS_OFFSET, 32'h0);
    chk("ls release", ls_vec, 32'h0);
    @(posedge i_ref_clk);
    #1;
    chk("far ls", alive[63:32], 32'hffff_ffff);
    wr(PSRB_LS_OFFSET, LS_DEF);
    @(posedge i_ref_clk);
    i_sys_rst <= 1'h1;
    @(posedge i_ref_clk);
    i_sys_rst <= 1'h0;
    rd(PSRB_HS_OFFSET, d);
    chk("hs rereset", d, 32'h0);
    chk("hs out rereset", hs_vec, 32'h0);
    chk("ls out rereset", ls_vec, 32'h0);
    end_sim();
  end
endmodule : psrb_bank_tb_top
`default_nettype wire

/* File: psrb_periph_model.sv */
// Purpose: far-side units fed by the bank
// Assumes: one bus clock
// Notes: a unit runs only while its reset is low
`timescale 1ns/100ps
`default_nettype none
module psrb_periph_model
(
  // clock
  input wire logic i_ref_clk,
  // reset lines, hs in 31:0, ls in 63:32
  input wire logic [63:0] i_unit_rst,
  // running flags
  output logic [63:0] o_unit_alive
);
  always_ff @(posedge i_ref_clk) begin
    o_unit_alive <= ~i_unit_rst;
  end
endmodule : psrb_periph_model
`default_nettype wire

/* File: psrb_pkg.sv */
// Purpose: constants for the peripheral soft reset bank
// Assumes: 32-bit register port, byte offsets
// Notes: reserved bits read as zero
package psrb_pkg;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] PSRB_HS_OFFSET = 8'h0c;
  localparam logic [7:0] PSRB_LS_OFFSET = 8'h10;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [31:0] PSRB_HS_RESET = 32'h0000_0000;
  localparam logic [31:0] PSRB_LS_RESET = 32'h0000_0000;
  // ------------------------------------------------------------
  // writable bit masks
  // ------------------------------------------------------------
  localparam logic [31:0] PSRB_HS_MASK = 32'h0000_5e7d;
  localparam logic [31:0] PSRB_LS_MASK = 32'h3e7e_c000;
  // ------------------------------------------------------------
  // high-speed field positions
  // ------------------------------------------------------------
  localparam int PSRB_HS_ALTFUNC_IO = 0;
  localparam int PSRB_HS_IO_PORT_A = 2;
  localparam int PSRB_HS_IO_PORT_E = 6;
  localparam int PSRB_HS_CONV_A = 9;
  localparam int PSRB_HS_CONV_B = 10;
  localparam int PSRB_HS_ADV_TIMER = 11;
  localparam int PSRB_HS_SPI0 = 12;
  localparam int PSRB_HS_SERIAL0 = 14;
  // ------------------------------------------------------------
  // low-speed field positions
  // ------------------------------------------------------------
  localparam int PSRB_LS_SPI1 = 14;
  localparam int PSRB_LS_SPI2 = 15;
  localparam int PSRB_LS_SERIAL1 = 17;
  localparam int PSRB_LS_SERIAL4 = 20;
  localparam int PSRB_LS_TWO_WIRE_A = 21;
  localparam int PSRB_LS_TWO_WIRE_B = 22;
  localparam int PSRB_LS_CAN_A = 25;
  localparam int PSRB_LS_CAN_B = 26;
  localparam int PSRB_LS_BACKUP_IF = 27;
  localparam int PSRB_LS_POWER_CTRL = 28;
  localparam int PSRB_LS_ANALOG_OUT = 29;
endpackage : psrb_pkg
